// File: lacs_pkg.sv
package lacs_pkg;

  // Link geometry: transceivers, channels per transceiver, word length.
  localparam int XCVR_MAX    = 3;
  localparam int CH_PER_XCVR = 8;
  localparam int CH_MAX      = XCVR_MAX * CH_PER_XCVR;
  localparam int WORD_BITS   = 32;
  localparam logic [3:0] LAST_SLOT = 4'h8;
  localparam logic [4:0] LAST_BIT  = 5'h1f;

  // Frame period and line supervision times.
  localparam int FRAME_US   = 125;
  localparam int SILENCE_MS = 2;
  // Least silence time, rounded up to whole frames.
  localparam int SILENCE_FRAMES = (SILENCE_MS * 1000 + FRAME_US - 1)
                                  / FRAME_US;
  localparam logic [4:0] SILENCE_CNT = 5'(SILENCE_FRAMES);
  // Clean frames needed before the line counts as activated.
  localparam logic [1:0] CLEAN_FRAMES = 2'h2;

  // Command codes written by software into a channel.
  localparam logic [3:0] DEACTIVATE_REQUEST_CMD = 4'h0;
  localparam logic [3:0] SOFT_RESET_CMD         = 4'h1;
  localparam logic [3:0] SINGLE_PULSE_TEST_CMD  = 4'h2;
  localparam logic [3:0] CONT_PULSE_TEST_CMD    = 4'h3;
  localparam logic [3:0] ACTIVATE_CMD           = 4'h8;
  localparam logic [3:0] LOOP_TWO_ACTIVATE_CMD  = 4'ha;
  localparam logic [3:0] ACTIVATED_CODE         = 4'hc;
  localparam logic [3:0] DEACTIVATE_CONFIRM_CMD = 4'hf;

  // Indication codes reported by a channel.
  localparam logic [3:0] TIMING_INDICATION    = 4'h0;
  localparam logic [3:0] RESYNC_INDICATION    = 4'h4;
  localparam logic [3:0] LINE_ONLY_ACT_IND    = 4'h7;
  localparam logic [3:0] ACTIVATE_REQ_IND     = 4'h8;
  localparam logic [3:0] ACTIVATED_INDICATION = 4'hc;
  localparam logic [3:0] DEACTIVATED_IND      = 4'hf;

  // Line signal selector carried in each channel command word.
  localparam logic [2:0] SIG_NONE        = 3'h0;
  localparam logic [2:0] SIG_SYNC        = 3'h1;
  localparam logic [2:0] SIG_USER_DATA   = 3'h2;
  localparam logic [2:0] SIG_TEST_SINGLE = 3'h3;
  localparam logic [2:0] SIG_TEST_CONT   = 3'h4;

  // Channel command word fields.
  localparam int CW_SIG_LSB = 0;
  localparam int CW_WAKE    = 3;
  localparam int CW_TBIT    = 4;
  // Channel status word fields.
  localparam int SW_SILENCE = 0;
  localparam int SW_WAKE    = 1;
  localparam int SW_RESP    = 2;
  localparam int SW_DATA    = 3;
  localparam int SW_FCV     = 4;

  // Register byte offsets and reset values.
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_XCMD_BASE  = 8'h04;
  localparam logic [7:0] REG_XSTAT_BASE = 8'h10;
  localparam logic [7:0] REG_CH_BASE    = 8'h40;
  localparam logic [1:0] CTRL_RESET     = 2'h0;
  localparam logic [31:0] XCMD_RESET    = 32'h0000_0000;

  // Channel activation states.
  typedef enum logic [3:0] {
    ST_RESET      = 4'b0000,
    ST_TEST       = 4'b0001,
    ST_PEND_DEACT = 4'b0010,
    ST_WAIT_DR    = 4'b0011,
    ST_DEACT      = 4'b0100,
    ST_PEND_ACT   = 4'b0101,
    ST_SYNC       = 4'b0110,
    ST_ACTIVE     = 4'b0111,
    ST_RESYNC     = 4'b1000
  } lacs_state_type;

  // Position of one bit within the command/status frame.
  typedef struct packed {
    logic [1:0] xcvr;
    logic [3:0] slot;
    logic [4:0] bit_idx;
  } lacs_pos_type;

endpackage

// File: lacs_top.sv
`timescale 1ns/1ns
// Overview of operation
// R1: Streams split into transceiver word then channel words.
// R2: Bits go channel by channel, same link clock.
// R3: One transceiver command word per connected transceiver.
// R4: One command word per channel of each transceiver.
// R5: Strap pins place each transceiver in its group.
// R6: Transceivers return transceiver and channel status words.
// R7: Reset pin or soft reset forces silent reset.
// R8: Test state sends single or continuous alternating pulses.
// R9: Test codes 0010 and 0011 accepted anywhere.
// R10: Pending deactivation waits 2 ms silence or confirm.
// R11: Deactivate request reaches pending deactivation from anywhere.
// R12: Silence or confirm leads to wait-for-request state.
// R13: Deactivated state wakes on terminal wake signal.
// R14: Wake or activate enters pending activation, sends sync.
// R15: Response signal moves channel to synchronized, sync continues.
// R16: Two clean frames give activated, user data sent.
// R17: Lost user data gives resync; response returns synchronized.
// R18: Code 0000 deactivates, line sends no signal.
// R19: Code 1000 activates; 1010 activates with loop, T set.
// R20: Code 1100 clears T bit; 1111 acknowledges deactivation.
// R21: Indicate 0111 when synchronous, 0100 when not.
// R22: Indicate 1111 after deactivation, 0000 when deactivated.
// R23: Each of 24 channels has own machine and registers.
module lacs_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        link_clk_i,
  input  wire logic        frame_sync_i,
  output logic             cmd_o,
  input  wire logic        stat_i
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [1:0]  link_clk_sync;   // Link clock synchroniser.
  logic [1:0]  frame_sync_sync; // Frame sync synchroniser.
  logic [1:0]  stat_sync;       // Status line synchroniser.
  logic        link_clk_d;      // Previous synchronised link clock.
  logic        frame_sync_d;    // Previous synchronised frame sync.
  logic        link_rise;       // Link clock rising edge seen.
  logic        link_fall;       // Link clock falling edge seen.
  logic        frame_start;     // Frame sync rising edge seen.
  logic        frame_pending;   // Frame start waits for next link edge.

  lacs_pkg::lacs_pos_type tx_pos;  // Next bit to put on the line.
  lacs_pkg::lacs_pos_type cur_pos; // Bit now standing on the line.
  logic        frame_live;      // Stream running within a frame.
  logic [31:0] rx_shift;        // Status word being assembled.

  logic [1:0]  xcvr_count;                     // Connected transceivers.
  logic [31:0] xcvr_cmd  [lacs_pkg::XCVR_MAX]; // Transceiver commands.
  logic [31:0] xcvr_stat [lacs_pkg::XCVR_MAX]; // Transceiver status.

  logic [3:0]  ch_cmd    [lacs_pkg::CH_MAX];   // Last command per channel.
  logic [3:0]  ch_ind    [lacs_pkg::CH_MAX];   // Indication per channel.
  lacs_pkg::lacs_state_type ch_state [lacs_pkg::CH_MAX];
  logic [31:0] ch_word   [lacs_pkg::CH_MAX];   // Outgoing channel words.
  logic [lacs_pkg::CH_MAX-1:0] cmd_pulse;      // New command written.
  logic [lacs_pkg::CH_MAX-1:0] stat_pulse;     // New status word in.
  logic [4:0]  stat_bits;                      // Last status word fields.

  logic        wb_req;          // Bus request awaiting acknowledge.
  logic [4:0]  ch_sel;          // Channel addressed by the bus.
  logic        ch_hit;          // Address falls in channel window.
  logic [4:0]  tx_ch;           // Channel of the outgoing word.
  logic [4:0]  rx_ch;           // Channel of the incoming word.
  logic [31:0] next_tx_word;    // Word currently being shifted out.
  logic [31:0] next_rd_data;    // Read data for the current address.

  //////////////////////////////////////////////////////////////////////////
  // Link input synchronisers and edge detection.

  // Every link input passes two flip-flops before use.
  always_ff @(posedge clk_i) begin
    link_clk_sync   <= {link_clk_sync[0], link_clk_i};
    frame_sync_sync <= {frame_sync_sync[0], frame_sync_i};
    stat_sync       <= {stat_sync[0], stat_i};
  end

  // The delayed copies look only at the second synchroniser stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_clk_d   <= 1'b0;
      frame_sync_d <= 1'b0;
    end else begin
      link_clk_d   <= link_clk_sync[1];
      frame_sync_d <= frame_sync_sync[1];
    end
  end

  assign link_rise   = link_clk_sync[1] & ~link_clk_d;
  assign link_fall   = ~link_clk_sync[1] & link_clk_d;
  assign frame_start = frame_sync_sync[1] & ~frame_sync_d;

  //////////////////////////////////////////////////////////////////////////
  // Frame position counter.

  // Channel index of the word at the transmit and receive positions.
  assign tx_ch = 5'(tx_pos.xcvr) * 5'h08 + 5'(tx_pos.slot) - 5'h01;
  assign rx_ch = 5'(cur_pos.xcvr) * 5'h08 + 5'(cur_pos.slot) - 5'h01;

  // A frame start rewinds the stream to transceiver 0, slot 0, bit 0.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pos        <= '0;
      cur_pos       <= '0;
      frame_live    <= 1'b0;
      frame_pending <= 1'b0;
    end else if (frame_start) begin
      frame_pending <= 1'b1;
    end else if (link_rise) begin
      if (frame_pending) begin
        // First bit of the frame goes out now.
        cur_pos       <= '0;
        tx_pos        <= '{xcvr: 2'h0, slot: 4'h0, bit_idx: 5'h01};
        frame_live    <= 1'b1;
        frame_pending <= 1'b0;
      end else if (frame_live) begin
        cur_pos <= tx_pos;
        // Words run transceiver word first, then its channels. see R1
        if (tx_pos.bit_idx != lacs_pkg::LAST_BIT) begin
          tx_pos.bit_idx <= tx_pos.bit_idx + 5'h01;
        end else begin
          tx_pos.bit_idx <= 5'h00;
          if (tx_pos.slot != lacs_pkg::LAST_SLOT) begin
            tx_pos.slot <= tx_pos.slot + 4'h1;
          end else begin
            tx_pos.slot <= 4'h0;
            tx_pos.xcvr <= tx_pos.xcvr + 2'h1;
          end
        end
        // The stream stops after the last connected transceiver.
        if (tx_pos.xcvr >= xcvr_count) begin
          frame_live <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command stream transmitter.

  // Pick the transceiver word or the channel word for this slot.
  always_comb begin
    next_tx_word = '0;
    if (tx_pos.xcvr < xcvr_count) begin
      if (tx_pos.slot == 4'h0) begin
        next_tx_word = xcvr_cmd[tx_pos.xcvr];          // see R3
      end else begin
        next_tx_word = ch_word[tx_ch];                 // see R4
      end
    end
  end

  // Bits leave least significant first, channel after channel. see R2
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_o <= 1'b0;
    end else if (link_rise) begin
      if (frame_pending) begin
        cmd_o <= xcvr_count != 2'h0 ? xcvr_cmd[0][0] : 1'b0;
      end else if (frame_live) begin
        cmd_o <= next_tx_word[tx_pos.bit_idx];
      end else begin
        cmd_o <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status stream receiver.

  // Status is sampled on the falling link edge, in the same order as
  // the command words, so each transceiver lands in its own group.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_shift   <= '0;
      stat_pulse <= '0;
      stat_bits  <= '0;
      for (int i = 0; i < lacs_pkg::XCVR_MAX; i++) begin
        xcvr_stat[i] <= '0;
      end
    end else begin
      stat_pulse <= '0;
      if (link_fall && frame_live) begin
        rx_shift <= {stat_sync[1], rx_shift[31:1]};
        if (cur_pos.bit_idx == lacs_pkg::LAST_BIT) begin
          if (cur_pos.slot == 4'h0) begin
            xcvr_stat[cur_pos.xcvr] <= {stat_sync[1], rx_shift[31:1]};
          end else begin
            stat_bits         <= rx_shift[5:1];        // see R6
            stat_pulse[rx_ch] <= 1'b1;                 // see R5
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-channel activation machines.

  for (genvar c = 0; c < lacs_pkg::CH_MAX; c++) begin : g_ch
    logic [4:0] silent_cnt; // Consecutive silent frames.
    logic [1:0] clean_cnt;  // Consecutive frames without F-bit violation.
    logic       t_bit;      // Transparent T bit sent with the signal.
    logic       test_cont;  // Continuous rather than single test pulses.
    logic [2:0] line_sig;   // Signal the transceiver must put on line.
    logic       wake_en;    // Wake detector enable.

    // Signal to send and wake detector use follow from the state.
    always_comb begin
      line_sig = lacs_pkg::SIG_NONE;                   // see R7 R18
      wake_en  = 1'b0;
      unique case (ch_state[c])
        lacs_pkg::ST_TEST: begin
          line_sig = test_cont ? lacs_pkg::SIG_TEST_CONT
                               : lacs_pkg::SIG_TEST_SINGLE; // see R8
        end
        lacs_pkg::ST_PEND_DEACT, lacs_pkg::ST_DEACT: begin
          wake_en = 1'b1;                              // see R10 R13
        end
        lacs_pkg::ST_PEND_ACT, lacs_pkg::ST_SYNC,
        lacs_pkg::ST_RESYNC: begin
          line_sig = lacs_pkg::SIG_SYNC;               // see R14 R15 R17
        end
        lacs_pkg::ST_ACTIVE: begin
          line_sig = lacs_pkg::SIG_USER_DATA;          // see R16
        end
        lacs_pkg::ST_RESET, lacs_pkg::ST_WAIT_DR: begin
          line_sig = lacs_pkg::SIG_NONE;
        end
      endcase
    end

    always_comb begin
      ch_word[c] = '0;
      ch_word[c][lacs_pkg::CW_SIG_LSB +: 3] = line_sig;
      ch_word[c][lacs_pkg::CW_WAKE]         = wake_en;
      ch_word[c][lacs_pkg::CW_TBIT]         = t_bit;
    end

    // Commands take priority over a status word in the same cycle.
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ch_state[c] <= lacs_pkg::ST_RESET;             // see R7 R23
        ch_ind[c]   <= lacs_pkg::TIMING_INDICATION;
        t_bit       <= 1'b0;
        test_cont   <= 1'b0;
        silent_cnt  <= '0;
        clean_cnt   <= '0;
      end else if (cmd_pulse[c]) begin
        silent_cnt <= '0;
        clean_cnt  <= '0;
        unique case (ch_cmd[c])
          lacs_pkg::DEACTIVATE_REQUEST_CMD: begin
            ch_state[c] <= lacs_pkg::ST_PEND_DEACT;    // see R11 R18
            ch_ind[c]   <= lacs_pkg::TIMING_INDICATION;
          end
          lacs_pkg::SOFT_RESET_CMD: begin
            ch_state[c] <= lacs_pkg::ST_RESET;         // see R7
            ch_ind[c]   <= lacs_pkg::TIMING_INDICATION;
          end
          lacs_pkg::SINGLE_PULSE_TEST_CMD,
          lacs_pkg::CONT_PULSE_TEST_CMD: begin
            ch_state[c] <= lacs_pkg::ST_TEST;          // see R9
            test_cont   <= ch_cmd[c][0];
          end
          lacs_pkg::ACTIVATE_CMD, lacs_pkg::LOOP_TWO_ACTIVATE_CMD: begin
            if (ch_state[c] == lacs_pkg::ST_WAIT_DR ||
                ch_state[c] == lacs_pkg::ST_DEACT) begin
              ch_state[c] <= lacs_pkg::ST_PEND_ACT;    // see R14 R19
              t_bit       <= ch_cmd[c][1];             // see R19
            end
          end
          lacs_pkg::ACTIVATED_CODE: begin
            t_bit <= 1'b0;                             // see R20
          end
          lacs_pkg::DEACTIVATE_CONFIRM_CMD: begin
            if (ch_state[c] == lacs_pkg::ST_PEND_DEACT) begin
              ch_state[c] <= lacs_pkg::ST_WAIT_DR;     // see R10 R12
              ch_ind[c]   <= lacs_pkg::DEACTIVATED_IND; // see R22
            end else if (ch_state[c] == lacs_pkg::ST_WAIT_DR) begin
              ch_state[c] <= lacs_pkg::ST_DEACT;       // see R20
              ch_ind[c]   <= lacs_pkg::TIMING_INDICATION; // see R22
            end
          end
          default: begin
            ch_state[c] <= ch_state[c];
          end
        endcase
      end else if (stat_pulse[c]) begin
        unique case (ch_state[c])
          lacs_pkg::ST_PEND_DEACT: begin
            // Only an unbroken run of silent frames counts.
            if (!stat_bits[lacs_pkg::SW_SILENCE]) begin
              silent_cnt <= '0;
            end else if (silent_cnt == lacs_pkg::SILENCE_CNT - 5'h01) begin
              ch_state[c] <= lacs_pkg::ST_WAIT_DR;     // see R10 R12
              ch_ind[c]   <= lacs_pkg::DEACTIVATED_IND; // see R22
              silent_cnt  <= '0;
            end else begin
              silent_cnt <= silent_cnt + 5'h01;
            end
          end
          lacs_pkg::ST_DEACT: begin
            if (stat_bits[lacs_pkg::SW_WAKE]) begin
              ch_state[c] <= lacs_pkg::ST_PEND_ACT;    // see R13 R14
              ch_ind[c]   <= lacs_pkg::ACTIVATE_REQ_IND;
            end
          end
          lacs_pkg::ST_PEND_ACT, lacs_pkg::ST_RESYNC: begin
            if (stat_bits[lacs_pkg::SW_RESP]) begin
              ch_state[c] <= lacs_pkg::ST_SYNC;        // see R15 R17
              ch_ind[c]   <= lacs_pkg::LINE_ONLY_ACT_IND; // see R21
              clean_cnt   <= '0;
            end
          end
          lacs_pkg::ST_SYNC: begin
            if (stat_bits[lacs_pkg::SW_FCV]) begin
              clean_cnt <= '0;
            end else if (clean_cnt == lacs_pkg::CLEAN_FRAMES - 2'h1) begin
              ch_state[c] <= lacs_pkg::ST_ACTIVE;      // see R16
              ch_ind[c]   <= lacs_pkg::ACTIVATED_INDICATION;
            end else begin
              clean_cnt <= clean_cnt + 2'h1;
            end
          end
          lacs_pkg::ST_ACTIVE: begin
            if (!stat_bits[lacs_pkg::SW_DATA]) begin
              ch_state[c] <= lacs_pkg::ST_RESYNC;      // see R17
              ch_ind[c]   <= lacs_pkg::RESYNC_INDICATION; // see R21
            end
          end
          lacs_pkg::ST_RESET, lacs_pkg::ST_TEST,
          lacs_pkg::ST_WAIT_DR: begin
            ch_state[c] <= ch_state[c];
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone register slave.

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign ch_sel = wb_adr_i[6:2] - 5'(lacs_pkg::REG_CH_BASE[7:2]);
  assign ch_hit = wb_adr_i >= lacs_pkg::REG_CH_BASE &&
                  ch_sel < 5'(lacs_pkg::CH_MAX) && wb_adr_i[1:0] == 2'h0;

  // Read data mux; unmapped addresses read as zero, except 0xc0 to 0xfc, which alias channels 0 to 15.
  always_comb begin
    next_rd_data = '0;
    if (ch_hit) begin
      next_rd_data = {20'h0, 4'(ch_state[ch_sel]), ch_cmd[ch_sel],
                      ch_ind[ch_sel]};
    end else begin
      unique case (wb_adr_i)
        lacs_pkg::REG_CTRL:           next_rd_data = {30'h0, xcvr_count};
        lacs_pkg::REG_XCMD_BASE:      next_rd_data = xcvr_cmd[0];
        lacs_pkg::REG_XCMD_BASE + 4:  next_rd_data = xcvr_cmd[1];
        lacs_pkg::REG_XCMD_BASE + 8:  next_rd_data = xcvr_cmd[2];
        lacs_pkg::REG_XSTAT_BASE:     next_rd_data = xcvr_stat[0];
        lacs_pkg::REG_XSTAT_BASE + 4: next_rd_data = xcvr_stat[1];
        lacs_pkg::REG_XSTAT_BASE + 8: next_rd_data = xcvr_stat[2];
        default:                      next_rd_data = '0;
      endcase
    end
  end

  // Every request is answered one cycle after it is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req && !wb_we_i ? next_rd_data : '0;
    end
  end

  // Control and transceiver command registers honour byte lanes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xcvr_count <= lacs_pkg::CTRL_RESET;
      for (int i = 0; i < lacs_pkg::XCVR_MAX; i++) begin
        xcvr_cmd[i] <= lacs_pkg::XCMD_RESET;
      end
    end else if (wb_req && wb_we_i) begin
      if (wb_adr_i == lacs_pkg::REG_CTRL && wb_sel_i[0]) begin
        // Only zero to three transceivers can be connected.
        xcvr_count <= wb_dat_i[1:0];
      end
      for (int i = 0; i < lacs_pkg::XCVR_MAX; i++) begin
        if (wb_adr_i == lacs_pkg::REG_XCMD_BASE + 8'(4 * i)) begin
          for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
              xcvr_cmd[i][8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
          end
        end
      end
    end
  end

  // A channel command write stores the code and wakes that machine.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_pulse <= '0;
      for (int i = 0; i < lacs_pkg::CH_MAX; i++) begin
        ch_cmd[i] <= lacs_pkg::SOFT_RESET_CMD;
      end
    end else begin
      cmd_pulse <= '0;
      if (wb_req && wb_we_i && ch_hit && wb_sel_i[0]) begin
        ch_cmd[ch_sel]    <= wb_dat_i[3:0];
        cmd_pulse[ch_sel] <= 1'b1;                     // see R23
      end
    end
  end

endmodule

// File: lacs_chk.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// Watches the register bus and the command stream.
module lacs_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        link_clk_i,
  input wire logic        cmd_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic       lk_d;   // Link clock one cycle late.
  logic [3:0] lk_age; // Cycles since the last link clock rise.
  // Ages the last link rise; saturates so long gaps stay quiet.
  always_ff @(posedge clk_i) begin
    lk_d <= link_clk_i;
    if (rst_i || (link_clk_i && !lk_d)) lk_age <= rst_i ? 4'hf : 4'h0;
    else if (lk_age != 4'hf) lk_age <= lk_age + 4'h1;
  end
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack_time;
    s_take |=> s_pulse;
  endproperty
  a_ack_time: assert property (p_ack_time)
    else $error("ack not one cycle after request");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
  property p_unmapped;
    s_take ##0 (!wb_we_i && wb_adr_i == 8'h30) |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_state_rd;
    s_take ##0 (!wb_we_i && wb_adr_i >= 8'h40 && wb_adr_i < 8'ha0)
      |=> wb_dat_o[11:8] <= 4'h8;
  endproperty
  a_state_rd: assert property (p_state_rd)
    else $error("channel state code out of range");
  property p_cmd_edge;
    $changed(cmd_o) |-> lk_age inside {[4'h1:4'h7]};
  endproperty
  a_cmd_edge: assert property (p_cmd_edge)
    else $error("command bit not tied to link clock rise");
  property p_cmd_hold;
    $changed(cmd_o) |=> $stable(cmd_o) [*8];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("command bit too short");
  property p_rst_quiet;
    $fell(rst_i) |-> !wb_ack_o && !cmd_o && wb_dat_o == 32'h0;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs busy after reset");
endmodule
bind lacs_top lacs_chk i_chk (.*);

// File: lacs_xcvr_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// One line transceiver strapped to group zero: it makes frame
// sync and link clock, returns status and records commands.
module lacs_xcvr_model (
  output logic      link_clk_o,
  output logic      frame_sync_o,
  output logic      stat_o,
  input  wire logic cmd_i
);
  logic [31:0] stat_word [0:8]; // Transceiver word, then ch 0..7.
  logic [31:0] cmd_word  [0:8]; // Command words seen, same order.
  // Idle lines and a recognisable transceiver status word.
  initial begin
    link_clk_o = 1'b0;
    frame_sync_o = 1'b0;
    stat_o = 1'b0;
    stat_word = '{default: 32'h0};
    stat_word[0] = 32'h0000_5a3c;
  end
  // One frame of 288 bits, low bit first; clock still between frames.
  task automatic frame();
    #3 frame_sync_o = 1'b1;
    #80 frame_sync_o = 1'b0;
    #80;
    for (int b = 0; b < 288; b++) begin
      link_clk_o = 1'b1;
      stat_o = stat_word[b / 32][b % 32];
      #80 link_clk_o = 1'b0;
      cmd_word[b / 32][b % 32] = cmd_i;
      #80;
    end
    stat_o = ~stat_o; // Released line shows no stale bit.
  endtask
endmodule

// File: lacs_top_tb.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
module lacs_top_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [1:0]  cs    = 2'h0;   // Bus cycle and strobe.
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] q;              // Last read data.
  wire  logic [31:0] rdat;
  wire  logic  ack, cmd, link_clk, fsync, stat;
  int          mismatches = 0;
  int          check_count = 0;
  initial forever #4 clk_i = ~clk_i;
  lacs_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cs[1]),
    .wb_stb_i(cs[0]), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .link_clk_i(link_clk), .frame_sync_i(fsync), .cmd_o(cmd),
    .stat_i(stat));
  lacs_xcvr_model i_xcvr (.link_clk_o(link_clk), .frame_sync_o(fsync),
    .stat_o(stat), .cmd_i(cmd));
  ////////////////////////////////////////////////////////////
  // Compares and counts.
  task automatic chk(input logic [31:0] seen, exp, input string what);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One classic bus cycle; holds until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    {cs, we, adr, wdat} <= {2'h3, w, a, d};
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    q = rdat;
    cs <= 2'h0;
  endtask
  task automatic wr_ch(input int ch, input logic [3:0] c);
    wb(1'b1, 8'(8'h40 + 4 * ch), {28'h0, c});
  endtask
  // Reads state, last command and indication of one channel.
  task automatic rd_ch(input int ch, input logic [11:0] exp);
    wb(1'b0, 8'(8'h40 + 4 * ch), 32'h0);
    chk({20'h0, q[11:0]}, {20'h0, exp}, "channel");
  endtask
  // Checks signal selector and T bit of channel 0's last word.
  task automatic sig(input logic t, input logic [2:0] s);
    chk({i_xcvr.cmd_word[1][4], i_xcvr.cmd_word[1][2:0]}, {t, s}, "sig");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    wb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0, "control");
    wb(1'b0, 8'h30, 32'h0);
    chk(q, 32'h0, "unmapped");
    rd_ch(23, 12'h010);
  endtask
  task automatic t_words();
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b1, 8'h04, 32'ha5c3_0f96);
    i_xcvr.frame();
    chk(i_xcvr.cmd_word[0], 32'ha5c3_0f96, "xcvr word");
    chk(i_xcvr.cmd_word[8], 32'h0, "reset word");
    wb(1'b0, 8'h10, 32'h0);
    chk(q, 32'h0000_5a3c, "xcvr status");
  endtask
  task automatic t_test();
    wr_ch(1, 4'h2);
    wr_ch(2, 4'h3);
    rd_ch(1, 12'h120);
    i_xcvr.frame();
    chk(i_xcvr.cmd_word[2][2:0], 3'h3, "single");
    chk(i_xcvr.cmd_word[3][2:0], 3'h4, "continuous");
  endtask
  task automatic t_deact();
    wr_ch(0, 4'h0);
    rd_ch(0, 12'h200);
    i_xcvr.frame();
    chk(i_xcvr.cmd_word[1][3:0], 4'h8, "pending");
    wr_ch(0, 4'hf);
    rd_ch(0, 12'h3ff);
    wr_ch(0, 4'hf);
    rd_ch(0, 12'h4f0);
    i_xcvr.stat_word[1] = 32'h2;
    i_xcvr.frame();
    chk(i_xcvr.cmd_word[1][3], 1'b1, "wake on");
    rd_ch(0, 12'h5f8);
  endtask
  task automatic t_act();
    wr_ch(0, 4'h0);
    wr_ch(0, 4'hf);
    wr_ch(0, 4'ha);
    i_xcvr.stat_word[1] = 32'h4;
    i_xcvr.frame();
    sig(1'b1, 3'h1);
    rd_ch(0, 12'h6a7);
    i_xcvr.stat_word[1] = 32'hc;
    i_xcvr.frame();
    i_xcvr.frame();
    rd_ch(0, 12'h7ac);
    wr_ch(0, 4'hc);
    i_xcvr.stat_word[1] = 32'h8;
    i_xcvr.frame();
    sig(1'b0, 3'h2);
    i_xcvr.stat_word[1] = 32'h0;
    i_xcvr.frame();
    rd_ch(0, 12'h8c4);
    i_xcvr.stat_word[1] = 32'h4;
    i_xcvr.frame();
    sig(1'b0, 3'h1);
    rd_ch(0, 12'h6c7);
    wr_ch(0, 4'h1);
    rd_ch(0, 12'h010);
  endtask
  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_words();
    t_test();
    t_deact();
    t_act();
    results();
  end
  // Ten frames take about 463 us; this leaves ample margin.
  initial begin
    #800000;
    mismatches++;
    results();
  end
endmodule
